/* File: rtcpit_pkg.sv */
package rtcpit_pkg;

	// Register indices; the byte address is four times the index
	localparam logic [7:0] IDX_IRQ_CTRL     = 8'h02;
	localparam logic [7:0] IDX_IRQ_FLAGS    = 8'h03;
	localparam logic [7:0] IDX_CMP_LO       = 8'h0C;
	localparam logic [7:0] IDX_CMP_HI       = 8'h0D;
	localparam logic [7:0] IDX_PIT_CTRL     = 8'h10;
	localparam logic [7:0] IDX_PIT_STATUS   = 8'h11;
	localparam logic [7:0] IDX_PIT_IRQ_EN   = 8'h12;
	localparam logic [7:0] IDX_PIT_IRQ_FLAG = 8'h13;
	localparam logic [7:0] IDX_PIT_DBG      = 8'h15;

	localparam int ADDR_W = 8;

	// Field positions
	localparam int POS_OVF         = 0;
	localparam int POS_CMP         = 1;
	localparam int POS_PIT_EN      = 0;
	localparam int POS_PERIOD_LO   = 3;
	localparam int POS_PERIOD_HI   = 6;
	localparam int POS_SYNC_BUSY   = 0;
	localparam int POS_PIT_IRQ     = 0;
	localparam int POS_RUN_HALTED  = 0;

	// Reset values
	localparam logic [15:0] RST_COMPARE = 16'h0000;
	localparam logic [7:0]  RST_PIT_CTRL = 8'h00;
	localparam logic [7:0]  RST_BYTE     = 8'h00;

	// Period field encodings
	localparam logic [3:0] PERIOD_OFF  = 4'h0;
	localparam logic [3:0] PERIOD_MIN  = 4'h1;
	localparam logic [3:0] PERIOD_MAX  = 4'hE;

	// Counter clock cycles from a write until it takes effect
	localparam logic [1:0] SYNC_CYCLES = 2'h2;

	// Writable bits of the periodic timer control register
	localparam logic [7:0] PIT_CTRL_MASK = 8'h79;

endpackage

/* File: rtcpit_sync_delay.sv */
`timescale 1ns/1ps
`default_nettype none

module rtcpit_sync_delay #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	// Load side
	input  wire logic         i_load,
	input  wire logic [W-1:0] i_data,
	input  wire logic [W-1:0] i_rst_val,
	// Effective side
	output var  logic [W-1:0] o_data,
	output var  logic         o_busy
);
	import rtcpit_pkg::*;

	logic [W-1:0] hold_q;
	logic [W-1:0] hold_d;
	logic [W-1:0] out_q;
	logic [W-1:0] out_d;
	logic [1:0]   cnt_q;
	logic [1:0]   cnt_d;
	logic         init_q;
	logic         init_d;

	always_comb begin
		hold_d = hold_q;
		out_d  = out_q;
		cnt_d  = cnt_q;
		init_d = 1'b1;
		// Reset value is caught after release, never under reset
		if (!init_q) begin
			out_d  = i_rst_val;
			hold_d = i_rst_val;
		end
		if (cnt_q == 2'h1) begin
			out_d = hold_q;
		end
		if (cnt_q != 2'h0) begin
			cnt_d = cnt_q - 2'h1;
		end
		// A new write restarts the delay; an older one is dropped unless it applies in this cycle
		if (i_load) begin
			hold_d = i_data;
			cnt_d  = SYNC_CYCLES;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hold_q <= '0;
			out_q  <= '0;
			cnt_q  <= 2'h0;
			init_q <= 1'b0;
		end else begin
			hold_q <= hold_d;
			out_q  <= out_d;
			cnt_q  <= cnt_d;
			init_q <= init_d;
		end
	end

	assign o_data = out_q;
	assign o_busy = (cnt_q != 2'h0);

endmodule

`default_nettype wire

/* File: rtcpit_top.sv */
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Operation
// RQ1 - Compare value split into low byte at base, high byte next index up.
// RQ2 - Both compare bytes are readable and writable by software.
// RQ3 - Period field bits 6:3 picks 4 to 32768 cycles; 0 and 0xF give none.
// RQ4 - Enable bit 0 of timer control starts periodic interrupts.
// RQ5 - Status bit 0 reads one while a control write is synchronising.
// RQ6 - Periodic interrupt enable gates the flag onto the interrupt output.
// RQ7 - Periodic flag sets on every timer interval, enabled or not.
// RQ8 - Writing one clears the periodic flag; zero leaves it.
// RQ9 - Without run-while-halted, the timer freezes during debug halt.
// RQ10 - With run-while-halted, the timer keeps running during debug halt.
// RQ11 - Compare flag sets when count equals compare; write one clears.
// RQ12 - Counter-domain writes take effect two clock cycles later.
// RQ13 - Compare and overflow enables gate their flags onto counter interrupt.
// RQ14 - Software waits for busy clear before rewriting timer control.
// RQ15 - Free-running prescaler gives one single-cycle pulse per interval.
module rtcpit_top #(
	parameter int PRESC_W = 15
) (
	// Clock and reset
	input  wire logic                          I_CLK,
	input  wire logic                          I_RST_N,
	// APB slave
	input  wire logic                          I_PSEL,
	input  wire logic                          I_PENABLE,
	input  wire logic                          I_PWRITE,
	input  wire logic [rtcpit_pkg::ADDR_W-1:0] I_PADDR,
	input  wire logic [31:0]                   I_PWDATA,
	output var  logic [31:0]                   O_PRDATA,
	output var  logic                          O_PREADY,
	output var  logic                          O_PSLVERR,
	// Counter side
	input  wire logic [15:0]                   I_COUNT_VALUE,
	input  wire logic                          I_COUNT_OVERFLOW,
	output var  logic [15:0]                   O_COMPARE_VALUE,
	// Debug
	input  wire logic                          I_DEBUG_HALT,
	// Interrupts and events
	output var  logic                          O_IRQ_COUNTER,
	output var  logic                          O_IRQ_PERIODIC,
	output var  logic                          O_PIT_EVENT
);
	import rtcpit_pkg::*;

	localparam logic [7:0] A_IRQ_CTRL     = 8'(4 * IDX_IRQ_CTRL);
	localparam logic [7:0] A_IRQ_FLAGS    = 8'(4 * IDX_IRQ_FLAGS);
	localparam logic [7:0] A_CMP_LO       = 8'(4 * IDX_CMP_LO);
	localparam logic [7:0] A_CMP_HI       = 8'(4 * IDX_CMP_HI);
	localparam logic [7:0] A_PIT_CTRL     = 8'(4 * IDX_PIT_CTRL);
	localparam logic [7:0] A_PIT_STATUS   = 8'(4 * IDX_PIT_STATUS);
	localparam logic [7:0] A_PIT_IRQ_EN   = 8'(4 * IDX_PIT_IRQ_EN);
	localparam logic [7:0] A_PIT_IRQ_FLAG = 8'(4 * IDX_PIT_IRQ_FLAG);
	localparam logic [7:0] A_PIT_DBG      = 8'(4 * IDX_PIT_DBG);

	// Bus phase decode
	logic        setup;
	logic        wr_acc;
	logic [7:0]  wbyte;

	// Software-side registers
	logic [15:0] compare_value_q;
	logic [15:0] compare_value_d;
	logic [7:0]  pit_ctrl_q;
	logic [7:0]  pit_ctrl_d;
	logic [1:0]  irq_ctrl_q;
	logic [1:0]  irq_ctrl_d;
	logic        pit_irq_en_q;
	logic        pit_irq_en_d;
	logic        run_while_halted_q;
	logic        run_while_halted_d;

	// Flags
	logic        cmp_flag_q;
	logic        cmp_flag_d;
	logic        ovf_flag_q;
	logic        ovf_flag_d;
	logic        pit_flag_q;
	logic        pit_flag_d;

	// Read path
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic        pslverr_q;
	logic        pslverr_d;
	logic        addr_hit;
	logic [7:0]  rbyte;

	// Synchronised copies
	logic        ld_cmp;
	logic        ld_ctrl;
	logic [15:0] cmp_eff;
	logic        cmp_busy;
	logic [7:0]  ctrl_eff;
	logic        ctrl_busy;

	// Periodic timer
	logic [PRESC_W-1:0] presc_q;
	logic [PRESC_W-1:0] presc_d;
	logic               pit_tick_q;
	logic               pit_tick_d;
	logic [3:0]         period;
	logic               pit_en;
	logic               pit_run;
	logic               period_ok;
	logic [15:0]        mask16;
	logic [PRESC_W-1:0] mask;
	logic               interval_hit;
	logic               cmp_match;

	assign setup  = I_PSEL && !I_PENABLE;
	assign wr_acc = I_PSEL && I_PENABLE && I_PWRITE;
	assign wbyte  = I_PWDATA[7:0];

	// Compare bytes and control reach the counter side via a delay stage
	assign ld_cmp  = wr_acc && (I_PADDR == A_CMP_LO || I_PADDR == A_CMP_HI);
	assign ld_ctrl = wr_acc && (I_PADDR == A_PIT_CTRL);

	rtcpit_sync_delay #(
		.W(16)
	) u_cmp_sync (
		.i_clk    (I_CLK),
		.i_rst_n  (I_RST_N),
		.i_load   (ld_cmp),
		.i_data   (compare_value_d),
		.i_rst_val(RST_COMPARE),
		.o_data   (cmp_eff),
		.o_busy   (cmp_busy)
	); // RQ12

	rtcpit_sync_delay #(
		.W(8)
	) u_ctrl_sync (
		.i_clk    (I_CLK),
		.i_rst_n  (I_RST_N),
		.i_load   (ld_ctrl),
		.i_data   (pit_ctrl_d),
		.i_rst_val(RST_PIT_CTRL),
		.o_data   (ctrl_eff),
		.o_busy   (ctrl_busy)
	); // RQ12

	// Software register writes
	always_comb begin
		compare_value_d    = compare_value_q;
		pit_ctrl_d         = pit_ctrl_q;
		irq_ctrl_d         = irq_ctrl_q;
		pit_irq_en_d       = pit_irq_en_q;
		run_while_halted_d = run_while_halted_q;
		if (wr_acc) begin
			case (I_PADDR)
				A_CMP_LO: begin
					compare_value_d[7:0] = wbyte; // RQ1
				end
				A_CMP_HI: begin
					compare_value_d[15:8] = wbyte; // RQ2
				end
				A_PIT_CTRL: begin
					pit_ctrl_d = wbyte & PIT_CTRL_MASK; // RQ3
				end
				A_IRQ_CTRL: begin
					irq_ctrl_d = wbyte[POS_CMP:POS_OVF];
				end
				A_PIT_IRQ_EN: begin
					pit_irq_en_d = wbyte[POS_PIT_IRQ];
				end
				A_PIT_DBG: begin
					run_while_halted_d = wbyte[POS_RUN_HALTED];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			compare_value_q    <= RST_COMPARE;
			pit_ctrl_q         <= RST_PIT_CTRL;
			irq_ctrl_q         <= 2'h0;
			pit_irq_en_q       <= 1'b0;
			run_while_halted_q <= 1'b0;
		end else begin
			compare_value_q    <= compare_value_d;
			pit_ctrl_q         <= pit_ctrl_d;
			irq_ctrl_q         <= irq_ctrl_d;
			pit_irq_en_q       <= pit_irq_en_d;
			run_while_halted_q <= run_while_halted_d;
		end
	end

	// Periodic timer, driven only by the synchronised control copy
	assign period    = ctrl_eff[POS_PERIOD_HI:POS_PERIOD_LO];
	assign pit_en    = ctrl_eff[POS_PIT_EN]; // RQ4
	assign period_ok = (period >= PERIOD_MIN) && (period <= PERIOD_MAX); // RQ3
	assign pit_run   = !I_DEBUG_HALT || run_while_halted_q; // RQ9 RQ10
	// Interval of 2^(period+1) cycles
	assign mask16    = (16'h0002 << period) - 16'h0001;
	assign mask      = mask16[PRESC_W-1:0];
	assign interval_hit = ((presc_q & mask) == mask);

	always_comb begin
		presc_d    = presc_q;
		pit_tick_d = 1'b0;
		// Halted timer neither counts nor fires
		if (pit_run) begin
			presc_d = presc_q + PRESC_W'(1); // RQ15
			pit_tick_d = pit_en && period_ok && interval_hit; // RQ15
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			presc_q    <= '0;
			pit_tick_q <= 1'b0;
		end else begin
			presc_q    <= presc_d;
			pit_tick_q <= pit_tick_d;
		end
	end

	// Flags: a set in the clearing cycle wins
	assign cmp_match = (I_COUNT_VALUE == cmp_eff);

	always_comb begin
		cmp_flag_d = cmp_flag_q;
		ovf_flag_d = ovf_flag_q;
		pit_flag_d = pit_flag_q;
		if (wr_acc && I_PADDR == A_IRQ_FLAGS) begin
			if (wbyte[POS_CMP]) begin
				cmp_flag_d = 1'b0; // RQ11
			end
			if (wbyte[POS_OVF]) begin
				ovf_flag_d = 1'b0;
			end
		end
		if (wr_acc && I_PADDR == A_PIT_IRQ_FLAG && wbyte[POS_PIT_IRQ]) begin
			pit_flag_d = 1'b0; // RQ8
		end
		if (cmp_match) begin
			cmp_flag_d = 1'b1; // RQ11
		end
		if (I_COUNT_OVERFLOW) begin
			ovf_flag_d = 1'b1;
		end
		if (pit_tick_q) begin
			pit_flag_d = 1'b1; // RQ7
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			cmp_flag_q <= 1'b0;
			ovf_flag_q <= 1'b0;
			pit_flag_q <= 1'b0;
		end else begin
			cmp_flag_q <= cmp_flag_d;
			ovf_flag_q <= ovf_flag_d;
			pit_flag_q <= pit_flag_d;
		end
	end

	// Read path, sampled in the setup cycle
	always_comb begin
		rbyte    = RST_BYTE;
		addr_hit = 1'b1;
		case (I_PADDR)
			A_CMP_LO: begin
				rbyte = compare_value_q[7:0]; // RQ1
			end
			A_CMP_HI: begin
				rbyte = compare_value_q[15:8]; // RQ2
			end
			A_PIT_CTRL: begin
				rbyte = pit_ctrl_q;
			end
			A_PIT_STATUS: begin
				rbyte[POS_SYNC_BUSY] = ctrl_busy; // RQ5
			end
			A_IRQ_CTRL: begin
				rbyte[POS_CMP:POS_OVF] = irq_ctrl_q;
			end
			A_IRQ_FLAGS: begin
				rbyte[POS_CMP] = cmp_flag_q;
				rbyte[POS_OVF] = ovf_flag_q;
			end
			A_PIT_IRQ_EN: begin
				rbyte[POS_PIT_IRQ] = pit_irq_en_q;
			end
			A_PIT_IRQ_FLAG: begin
				rbyte[POS_PIT_IRQ] = pit_flag_q;
			end
			A_PIT_DBG: begin
				rbyte[POS_RUN_HALTED] = run_while_halted_q;
			end
			default: begin
				addr_hit = 1'b0;
			end
		endcase
	end

	always_comb begin
		prdata_d  = prdata_q;
		pslverr_d = pslverr_q;
		if (setup) begin
			prdata_d  = {24'h000000, rbyte};
			pslverr_d = !addr_hit;
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			prdata_q  <= 32'h00000000;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q  <= prdata_d;
			pslverr_q <= pslverr_d;
		end
	end

	// Zero wait states; error only meaningful during access
	assign O_PREADY  = 1'b1;
	assign O_PSLVERR = I_PSEL && I_PENABLE && pslverr_q;
	assign O_PRDATA  = prdata_q;

	// Outputs
	assign O_COMPARE_VALUE = cmp_eff;
	assign O_IRQ_COUNTER = (cmp_flag_q && irq_ctrl_q[POS_CMP])
		|| (ovf_flag_q && irq_ctrl_q[POS_OVF]); // RQ13
	assign O_IRQ_PERIODIC = pit_flag_q && pit_irq_en_q; // RQ6
	assign O_PIT_EVENT    = pit_tick_q; // RQ15

	// cmp_busy is kept for symmetry but software has no status bit for it
	logic unused_ok;
	assign unused_ok = cmp_busy;

endmodule

`default_nettype wire

/* File: rtcpit_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcpit_checker (
	// Clock and reset
	input  wire logic                          I_CLK,
	input  wire logic                          I_RST_N,
	// APB
	input  wire logic                          I_PSEL,
	input  wire logic                          I_PENABLE,
	input  wire logic                          I_PWRITE,
	input  wire logic [rtcpit_pkg::ADDR_W-1:0] I_PADDR,
	input  wire logic [31:0]                   I_PWDATA,
	input  wire logic [31:0]                   O_PRDATA,
	input  wire logic                          O_PREADY,
	input  wire logic                          O_PSLVERR,
	// Timer side
	input  wire logic                          I_DEBUG_HALT,
	input  wire logic [15:0]                   O_COMPARE_VALUE,
	input  wire logic                          O_IRQ_PERIODIC,
	input  wire logic                          O_PIT_EVENT
);
	import rtcpit_pkg::*;
	logic acc;
	logic wr;
	logic dbg_d;
	logic dbg_q;
	assign acc = I_PSEL && I_PENABLE;
	assign wr = acc && I_PWRITE;
	always_comb begin
		dbg_d = dbg_q;
		if (wr && I_PADDR == 8'h54) begin
			dbg_d = I_PWDATA[0];
		end
	end
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			dbg_q <= 1'b0;
		end else begin
			dbg_q <= dbg_d;
		end
	end
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);
	AST_READY: assert property (acc |-> O_PREADY)
		else $error("access without ready");
	AST_RDATA_HI: assert property (acc && !I_PWRITE |->
		O_PRDATA[31:8] == 24'h0)
		else $error("read data upper bits set");
	AST_UNMAPPED: assert property (acc && !(I_PADDR inside
		{8'h08, 8'h0C, 8'h30, 8'h34, 8'h40, 8'h44, 8'h48, 8'h4C, 8'h54})
		|-> O_PSLVERR)
		else $error("unmapped access without error");
	AST_PULSE_GAP: assert property (O_PIT_EVENT |=> !O_PIT_EVENT [*3])
		else $error("timer pulses closer than four cycles");
	AST_CMP_SYNC: assert property (wr && I_PADDR == 8'h30 |-> ##3
		O_COMPARE_VALUE[7:0] == $past(I_PWDATA[7:0], 3))
		else $error("compare low byte not applied after sync");
	AST_CMP_EARLY: assert property (wr && I_PADDR == 8'h30 |-> ##2
		$stable(O_COMPARE_VALUE))
		else $error("compare value applied before sync delay");
	AST_IRQ_RISE: assert property ($rose(O_IRQ_PERIODIC) |->
		$past(O_PIT_EVENT) || $past(wr && I_PADDR == 8'h48))
		else $error("periodic irq rose without cause");
	AST_FLAG_CLR: assert property (wr && I_PADDR == 8'h4C
		&& I_PWDATA[0] && !O_PIT_EVENT |=> !O_IRQ_PERIODIC)
		else $error("periodic flag not cleared");
	AST_HALT: assert property (I_DEBUG_HALT && !dbg_q
		&& $past(I_DEBUG_HALT) && !$past(dbg_q) |-> !O_PIT_EVENT)
		else $error("timer pulsed while halted");
	COV_EVENT: cover property (O_PIT_EVENT);
	COV_ERR: cover property (acc && O_PSLVERR);
	COV_IRQ: cover property ($rose(O_IRQ_PERIODIC));
endmodule
bind rtcpit_top rtcpit_checker u_chk (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
	.I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE),
	.I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
	.O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_DEBUG_HALT(I_DEBUG_HALT),
	.O_COMPARE_VALUE(O_COMPARE_VALUE), .O_IRQ_PERIODIC(O_IRQ_PERIODIC),
	.O_PIT_EVENT(O_PIT_EVENT));
`default_nettype wire

/* File: rtcpit_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
	mismatches++; \
	$display("unexpected %s exp %0h got %0h", nm, (e), (g)); end end
module rtcpit_top_tb;
	import rtcpit_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n, psel, penable, pwrite, ovf, halt, e;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic        pready, pslverr, irq_c, irq_p, ev;
	logic [15:0] cnt, cmpv;
	int          mismatches, checked, n;
	logic [7:0]  regs [9] = '{8'h08, 8'h0C, 8'h30, 8'h34, 8'h40, 8'h44,
		8'h48, 8'h4C, 8'h54};
	logic [3:0]  per [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hF, 4'hE};
	int          win [7] = '{64, 64, 64, 64, 64, 64, 65536};
	int          exp_n [7] = '{0, 16, 8, 4, 2, 0, 2};
	always #2.5 clk = ~clk;
	rtcpit_top dut (.I_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel),
		.I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
		.I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
		.O_PSLVERR(pslverr), .I_COUNT_VALUE(cnt), .I_COUNT_OVERFLOW(ovf),
		.O_COMPARE_VALUE(cmpv), .I_DEBUG_HALT(halt), .O_IRQ_COUNTER(irq_c),
		.O_IRQ_PERIODIC(irq_p), .O_PIT_EVENT(ev));
	task automatic test_done();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Idle cycle before each setup keeps one driver edge per signal
	task automatic xfer(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (k >= 16) begin
			mismatches++;
			test_done();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		xfer(a, 1'b0, 32'h0);
		`CHK("prdata", x, r)
	endtask
	task automatic pulses(input int c);
		n = 0;
		repeat (c) begin
			@(posedge clk);
			n += int'(ev === 1'b1);
		end
	endtask
	initial begin
		{rst_n, psel, penable, pwrite, ovf, halt} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		cnt = 16'h1234;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		foreach (regs[i]) rd(regs[i], 32'h0);
		xfer(8'h30, 1'b1, 32'hA5);
		xfer(8'h34, 1'b1, 32'h3C);
		rd(8'h30, 32'hA5);
		rd(8'h34, 32'h3C);
		`CHK("compare", 16'h3CA5, cmpv)
		xfer(8'h08, 1'b1, 32'h3);
		cnt <= 16'h3CA5;
		@(posedge clk);
		cnt <= 16'h0001;
		repeat (2) @(posedge clk);
		`CHK("irq_cnt", 1'b1, irq_c)
		rd(8'h0C, 32'h2);
		xfer(8'h0C, 1'b1, 32'h2);
		repeat (2) @(posedge clk);
		`CHK("irq_cnt", 1'b0, irq_c)
		ovf <= 1'b1;
		@(posedge clk);
		ovf <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK("irq_cnt", 1'b1, irq_c)
		xfer(8'h0C, 1'b1, 32'h1);
		xfer(8'h50, 1'b0, 32'h0);
		`CHK("unmapped", 1'b1, e)
		xfer(8'h44, 1'b1, 32'hFF);
		xfer(8'h40, 1'b1, 32'h09);
		rd(8'h44, 32'h1);
		repeat (4) @(posedge clk);
		rd(8'h44, 32'h0);
		rd(8'h40, 32'h09);
		xfer(8'h40, 1'b1, 32'hFF);
		rd(8'h40, 32'h79);
		foreach (per[i]) begin
			xfer(8'h40, 1'b1, {25'h0, per[i], 3'h1});
			repeat (4) @(posedge clk);
			pulses(win[i]);
			`CHK("pulses", exp_n[i], n)
		end
		xfer(8'h40, 1'b1, 32'h08);
		repeat (4) @(posedge clk);
		pulses(64);
		`CHK("pulses", 0, n)
		rd(8'h4C, 32'h1);
		`CHK("irq_per", 1'b0, irq_p)
		xfer(8'h48, 1'b1, 32'h1);
		repeat (2) @(posedge clk);
		`CHK("irq_per", 1'b1, irq_p)
		xfer(8'h4C, 1'b1, 32'h0);
		rd(8'h4C, 32'h1);
		xfer(8'h4C, 1'b1, 32'h1);
		rd(8'h4C, 32'h0);
		halt <= 1'b1;
		xfer(8'h40, 1'b1, 32'h09);
		repeat (4) @(posedge clk);
		pulses(64);
		`CHK("pulses", 0, n)
		xfer(8'h54, 1'b1, 32'h1);
		// Frozen prescaler phase is arbitrary; count only whole intervals
		repeat (4) @(posedge clk);
		pulses(64);
		`CHK("pulses", 16, n)
		halt <= 1'b0;
		test_done();
	end
endmodule
`default_nettype wire
